// ===== hdl/slsc_top.sv
// Purpose: Line state controller for one subscriber channel with Wishbone registers
// Assumes: Ring trip and voltage inputs come from same-clock logic
// Notes:   Line controls are registered, one cycle behind the effective state
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module slsc_top
  import slsc_pkg::*;
#(
  parameter int CAL_CYCLES  = CAL_CYC,
  parameter int RING_CYCLES = RING_PERIOD_CYC,
  parameter int VW          = 16
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  // Ringing datapath
  input  wire logic                 ring_trip,
  input  wire logic signed [VW-1:0] ring_inst_v,
  input  wire logic signed [VW-1:0] line_target_v,
  // Line controls
  output logic                      reg_on,
  output logic                      reg_floor,
  output logic                      reg_track,
  output logic                      reg_fixed,
  output logic                      drv_hiz,
  output logic                      feed_en,
  output logic                      hook_sup_en,
  output logic                      voice_tx_en,
  output logic                      voice_ch_en,
  output logic                      rev_pol,
  output logic                      tip_open,
  output logic                      lp_bias_en,
  output logic                      line_mon_en,
  output logic                      ring_gen_en,
  output logic                      ring_apply,
  output logic                      bias_gen_en,
  output logic                      ring_ilim_en,
  output logic                      balanced_en,
  // Interrupt
  output logic                      irq
);

  typedef struct packed {
    logic reg_on;
    logic reg_floor;
    logic reg_track;
    logic reg_fixed;
    logic drv_hiz;
    logic feed_en;
    logic hook_sup_en;
    logic voice_tx_en;
    logic voice_ch_en;
    logic rev_pol;
    logic tip_open;
    logic lp_bias_en;
    logic line_mon_en;
    logic ring_gen_en;
    logic ring_apply;
    logic bias_gen_en;
    logic ring_ilim_en;
    logic balanced_en;
  } slsc_lctl_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [3:0]  ctrl;
    logic [3:0]  cfg;
    logic [3:0]  eff;
    logic [2:0]  ist;
    logic [2:0]  imask;
    slsc_lctl_t  lc;
  } slsc_top_t;

  slsc_top_t q;
  slsc_top_t n;

  logic       req;
  logic       wr;
  logic       cal_start;
  logic       line_init;
  logic       trip_take;
  logic       cal_busy;
  logic       cal_done;
  logic       ring_gen;
  logic       ring_applied;
  logic       ring_busy;
  logic [2:0] ev;

  // Per-state line control decode
  function automatic slsc_lctl_t line_ctl(input logic [3:0] eff, input logic [3:0] cfg,
                                          input logic gen);
    slsc_lctl_t c;
    c = '0;
    c.ring_gen_en = gen;
    c.bias_gen_en = gen;
    case (eff[2:0])
      LS_SHUTDOWN: begin
        c.ring_gen_en = 1'b0;
        c.bias_gen_en = 1'b0;
      end
      LS_DISCONNECT: begin
        c.reg_on      = 1'b1;
        c.reg_floor   = 1'b1;
        c.drv_hiz     = 1'b1;
        c.voice_ch_en = cfg[CFG_MON_BIT];
      end
      LS_STANDBY: begin
        c.reg_on  = 1'b1;
        c.rev_pol = eff[CTRL_REV_BIT];
        if (cfg[CFG_LOWPWR_BIT]) begin
          c.lp_bias_en  = 1'b1;
          c.line_mon_en = 1'b1;
        end else begin
          c.feed_en     = 1'b1;
          c.hook_sup_en = 1'b1;
        end
      end
      LS_TIP_OPEN: begin
        c.reg_on      = 1'b1;
        c.feed_en     = 1'b1;
        c.hook_sup_en = 1'b1;
        c.tip_open    = 1'b1;
        c.rev_pol     = eff[CTRL_REV_BIT];
      end
      LS_OHT, LS_TALK: begin
        c.reg_on      = 1'b1;
        c.feed_en     = 1'b1;
        c.hook_sup_en = 1'b1;
        c.voice_tx_en = 1'b1;
        c.voice_ch_en = 1'b1;
        c.rev_pol     = eff[CTRL_REV_BIT];
      end
      LS_ACTIVE: begin
        c.reg_on      = 1'b1;
        c.feed_en     = 1'b1;
        c.hook_sup_en = 1'b1;
        c.rev_pol     = eff[CTRL_REV_BIT];
      end
      LS_RINGING: begin
        c.reg_on       = 1'b1;
        c.ring_gen_en  = 1'b1;
        c.ring_apply   = 1'b1;
        c.ring_ilim_en = 1'b1;
        c.bias_gen_en  = 1'b1;
        c.reg_fixed    = cfg[CFG_FIXED_BIT];
        c.reg_track    = !cfg[CFG_FIXED_BIT];
        c.balanced_en  = cfg[CFG_BAL_BIT];
        c.rev_pol      = eff[CTRL_REV_BIT];
      end
      default: begin
        c = '0;
      end
    endcase
    return c;
  endfunction

  // Ack is registered, so every access takes two cycles
  assign req       = wb_cyc_i && wb_stb_i && !q.ack;
  assign wr        = req && wb_we_i && wb_sel_i[0];
  assign cal_start = wr && (wb_adr_i == ADDR_CAL_CMD) && wb_dat_i[CAL_START_BIT];
  assign line_init = wr && (wb_adr_i == ADDR_CAL_CMD) && wb_dat_i[CAL_INIT_BIT];
  assign trip_take = ring_trip && ring_applied && (q.ctrl[2:0] == LS_RINGING);

  always_comb begin
    n = q;
    n.ack = req;
    if (wr) begin
      case (wb_adr_i)
        ADDR_LINE_CTRL: n.ctrl  = wb_dat_i[3:0];
        ADDR_LINE_CFG:  n.cfg   = wb_dat_i[3:0];
        ADDR_INT_MASK:  n.imask = wb_dat_i[2:0];
        default: ;
      endcase
    end
    // A trip ends ringing into active, keeping polarity
    if (trip_take) begin
      n.ctrl = {q.ctrl[CTRL_REV_BIT], LS_ACTIVE};
    end
    if (line_init) begin
      n.ctrl = {1'b0, LS_DISCONNECT};
    end
    // Effective state waits while entry or exit is in progress;
    // a ringing request only lands once the sequencer applies it
    if (ring_applied) begin
      n.eff = {q.ctrl[CTRL_REV_BIT], LS_RINGING};
    end else if (!ring_busy && (q.ctrl[2:0] != LS_RINGING)) begin
      n.eff = q.ctrl;
    end
    ev = '0;
    ev[INT_CAL_BIT]   = cal_done;
    ev[INT_TRIP_BIT]  = trip_take;
    ev[INT_STATE_BIT] = n.eff != q.eff;
    // Set wins over a same-cycle clear
    if (wr && (wb_adr_i == ADDR_INT_STAT)) begin
      n.ist = (q.ist & ~wb_dat_i[2:0]) | ev;
    end else begin
      n.ist = q.ist | ev;
    end
    n.rdat = 32'h0;
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        ADDR_LINE_CTRL: n.rdat = {28'h0, q.ctrl};
        ADDR_LINE_CFG:  n.rdat = {28'h0, q.cfg};
        ADDR_CAL_CMD:   n.rdat = {31'h0, cal_busy};
        ADDR_LINE_STAT: n.rdat = {25'h0, ring_busy, ring_applied, ring_gen, q.eff};
        ADDR_INT_STAT:  n.rdat = {29'h0, q.ist};
        ADDR_INT_MASK:  n.rdat = {29'h0, q.imask};
        default:        n.rdat = 32'h0;
      endcase
    end
    n.lc = line_ctl(q.eff, q.cfg, ring_gen);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q       <= '0;
      q.ctrl  <= CTRL_RST;
      q.cfg   <= CFG_RST;
      q.eff   <= CTRL_RST;
      q.imask <= MASK_RST;
    end else begin
      q <= n;
    end
  end

  slsc_cal #(
    .CYC (CAL_CYCLES)
  ) u_cal (
    .clk   (clk),
    .rst   (rst),
    .start (cal_start),
    .busy  (cal_busy),
    .done  (cal_done)
  );

  slsc_ring #(
    .PERIOD_CYC (RING_CYCLES),
    .VW         (VW)
  ) u_ring (
    .clk           (clk),
    .rst           (rst),
    .want_ring     (q.ctrl[2:0] == LS_RINGING),
    .ring_inst_v   (ring_inst_v),
    .line_target_v (line_target_v),
    .gen_on        (ring_gen),
    .applied       (ring_applied),
    .busy          (ring_busy)
  );

  assign wb_ack_o     = q.ack;
  assign wb_dat_o     = q.rdat;
  assign irq          = |(q.ist & q.imask);
  assign reg_on       = q.lc.reg_on;
  assign reg_floor    = q.lc.reg_floor;
  assign reg_track    = q.lc.reg_track;
  assign reg_fixed    = q.lc.reg_fixed;
  assign drv_hiz      = q.lc.drv_hiz;
  assign feed_en      = q.lc.feed_en;
  assign hook_sup_en  = q.lc.hook_sup_en;
  assign voice_tx_en  = q.lc.voice_tx_en;
  assign voice_ch_en  = q.lc.voice_ch_en;
  assign rev_pol      = q.lc.rev_pol;
  assign tip_open     = q.lc.tip_open;
  assign lp_bias_en   = q.lc.lp_bias_en;
  assign line_mon_en  = q.lc.line_mon_en;
  assign ring_gen_en  = q.lc.ring_gen_en;
  assign ring_apply   = q.lc.ring_apply;
  assign bias_gen_en  = q.lc.bias_gen_en;
  assign ring_ilim_en = q.lc.ring_ilim_en;
  assign balanced_en  = q.lc.balanced_en;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  cal_event_a: assert property (cal_done |=> q.ist[INT_CAL_BIT] && cal_busy == $past(cal_start)) else $error("calibration event lost");
  init_disc_a: assert property (line_init |=> q.ctrl == {1'b0, LS_DISCONNECT}) else $error("init did not give disconnect");
  shut_off_a: assert property ((q.eff[2:0] == LS_SHUTDOWN) |=> !reg_on && !voice_ch_en && !feed_en && !ring_gen_en) else $error("shutdown not all off");
  disc_hiz_a: assert property ((q.eff[2:0] == LS_DISCONNECT) |=> drv_hiz && reg_on && reg_floor && !feed_en && voice_ch_en == $past(q.cfg[CFG_MON_BIT])) else $error("disconnect controls wrong");
  stby_gen_a: assert property ((q.eff[2:0] == LS_STANDBY && !q.cfg[CFG_LOWPWR_BIT]) |=> feed_en && hook_sup_en && !voice_tx_en && rev_pol == $past(q.eff[CTRL_REV_BIT])) else $error("generic standby wrong");
  stby_lp_a: assert property ((q.eff[2:0] == LS_STANDBY && q.cfg[CFG_LOWPWR_BIT]) |=> !feed_en && lp_bias_en && line_mon_en && !voice_tx_en) else $error("low power standby wrong");
  oht_voice_a: assert property ((q.eff[2:0] == LS_OHT) |=> feed_en && voice_tx_en && hook_sup_en) else $error("on-hook transmit wrong");
  talk_voice_a: assert property ((q.eff[2:0] == LS_ACTIVE || q.eff[2:0] == LS_TALK) |=> feed_en && hook_sup_en && (voice_tx_en == ($past(q.eff[2:0]) == LS_TALK))) else $error("active or talk voice wrong");
  ring_drive_a: assert property ((q.eff[2:0] == LS_RINGING) |=> ring_apply && ring_ilim_en && bias_gen_en && ring_gen_en) else $error("ringing drive wrong");
  ring_entry_a: assert property (ring_applied && !$past(ring_applied) |=> q.eff[2:0] == LS_RINGING) else $error("ringing state not entered");
  ring_exit_a: assert property (ring_applied |=> q.eff[2:0] == LS_RINGING) else $error("left ringing during exit");
  reg_mode_a: assert property ((q.eff[2:0] == LS_RINGING) |=> (reg_track != reg_fixed) && reg_fixed == $past(q.cfg[CFG_FIXED_BIT])) else $error("regulator mode wrong");
  bal_drive_a: assert property ((q.eff[2:0] == LS_RINGING) |=> balanced_en == $past(q.cfg[CFG_BAL_BIT])) else $error("balanced drive wrong");
  ctrl_hold_a: assert property (!(wr && wb_adr_i == ADDR_LINE_CTRL) && !line_init && !trip_take |=> $stable(q.ctrl)) else $error("state field changed alone");
  eff_take_a: assert property (!ring_busy && !ring_applied && q.ctrl[2:0] != LS_RINGING |=> q.eff == $past(q.ctrl)) else $error("state not applied in one update");
  ring_hold_a: assert property (q.ctrl[2:0] == LS_RINGING && !ring_applied |=> $stable(q.eff)) else $error("ringing state taken before entry");

  cal_seen_c: cover property (cal_done ##1 irq);
  ring_on_c: cover property (q.ctrl[2:0] == LS_RINGING ##[1:20] ring_applied);
  trip_c: cover property (trip_take ##[1:40] !ring_busy);
  lp_stby_c: cover property (q.eff[2:0] == LS_STANDBY && q.cfg[CFG_LOWPWR_BIT]);

endmodule
`default_nettype wire

// ===== hdl/slsc_pkg.sv
// Purpose: Shared constants for the subscriber line state controller
// Assumes: Classic Wishbone slave, 32-bit data, byte addresses, 200 MHz clock
// Notes:   Line state codes are the host-visible encoding of the state field
package slsc_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_LINE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_LINE_CFG  = 8'h04;
  localparam logic [7:0] ADDR_CAL_CMD   = 8'h08;
  localparam logic [7:0] ADDR_LINE_STAT = 8'h0C;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h10;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h14;

  // Line state codes
  localparam logic [2:0] LS_SHUTDOWN   = 3'h0;
  localparam logic [2:0] LS_DISCONNECT = 3'h1;
  localparam logic [2:0] LS_STANDBY    = 3'h2;
  localparam logic [2:0] LS_TIP_OPEN   = 3'h3;
  localparam logic [2:0] LS_OHT        = 3'h4;
  localparam logic [2:0] LS_ACTIVE     = 3'h5;
  localparam logic [2:0] LS_TALK       = 3'h6;
  localparam logic [2:0] LS_RINGING    = 3'h7;

  // Field positions
  localparam int CTRL_REV_BIT    = 3;
  localparam int CFG_LOWPWR_BIT  = 0;
  localparam int CFG_FIXED_BIT   = 1;
  localparam int CFG_BAL_BIT     = 2;
  localparam int CFG_MON_BIT     = 3;
  localparam int CAL_START_BIT   = 0;
  localparam int CAL_INIT_BIT    = 1;
  localparam int INT_CAL_BIT     = 0;
  localparam int INT_TRIP_BIT    = 1;
  localparam int INT_STATE_BIT   = 2;

  // Reset values
  localparam logic [3:0] CTRL_RST = {1'b0, LS_SHUTDOWN};
  localparam logic [3:0] CFG_RST  = 4'h0;
  localparam logic [2:0] MASK_RST = 3'h0;

  // Timing
  localparam int CLK_FREQ_MHZ    = 200;
  localparam int CAL_TIME_US     = 1000;
  localparam int CAL_CYC         = CAL_TIME_US * CLK_FREQ_MHZ;
  localparam int RING_PERIOD_US  = 50000;
  localparam int RING_PERIOD_CYC = RING_PERIOD_US * CLK_FREQ_MHZ;
  localparam int RING_TOL        = 16;

endpackage

// ===== hdl/slsc_cal.sv
// Purpose: Non-blocking line calibration sequencer
// Assumes: start is a one-cycle pulse from the register block
// Notes:   A start while busy is ignored; the run is not restarted
`timescale 1ns/1ps
`default_nettype none
module slsc_cal
  import slsc_pkg::*;
#(
  parameter int CYC = CAL_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  typedef struct packed {
    logic        busy;
    logic        done;
    logic [31:0] cnt;
  } slsc_cal_t;

  slsc_cal_t c_q;
  slsc_cal_t c_d;

  always_comb begin
    c_d = c_q;
    c_d.done = 1'b0;
    if (c_q.busy) begin
      if (c_q.cnt >= 32'(CYC - 1)) begin
        c_d.busy = 1'b0;
        c_d.done = 1'b1;
      end else begin
        c_d.cnt = c_q.cnt + 32'h1;
      end
    end else if (start) begin
      c_d.busy = 1'b1;
      c_d.cnt  = 32'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      c_q <= '0;
    end else begin
      c_q <= c_d;
    end
  end

  assign busy = c_q.busy;
  assign done = c_q.done;

  cal_len_a: assert property (@(posedge clk) disable iff (rst) start && !busy |=> busy[*2]) else $error("calibration ended too early");

endmodule
`default_nettype wire

// ===== hdl/slsc_ring.sv
// Purpose: Ring entry and ring exit sequencing
// Assumes: ring_inst_v and line_target_v come from the same-clock datapath
// Notes:   Exit is also bounded by one period so a stuck comparator cannot hold ringing
`timescale 1ns/1ps
`default_nettype none
module slsc_ring
  import slsc_pkg::*;
#(
  parameter int PERIOD_CYC = RING_PERIOD_CYC,
  parameter int VW         = 16
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Request and voltages
  input  wire logic                 want_ring,
  input  wire logic signed [VW-1:0] ring_inst_v,
  input  wire logic signed [VW-1:0] line_target_v,
  // Sequencing status
  output logic                      gen_on,
  output logic                      applied,
  output logic                      busy
);

  typedef enum logic [3:0] {
    RS_IDLE  = 4'b0001,
    RS_ENTRY = 4'b0010,
    RS_ON    = 4'b0100,
    RS_EXIT  = 4'b1000
  } slsc_rstate_t;

  typedef struct packed {
    slsc_rstate_t st;
    logic [31:0]  cnt;
  } slsc_ring_t;

  slsc_ring_t        r_q;
  slsc_ring_t        r_d;
  logic signed [VW:0] diff;
  logic signed [VW:0] tol;
  logic               match;
  logic               expired;

  assign diff    = {ring_inst_v[VW-1], ring_inst_v} - {line_target_v[VW-1], line_target_v};
  assign tol     = (VW+1)'(RING_TOL);
  assign match   = (diff <= tol) && (diff >= -tol);
  assign expired = r_q.cnt >= 32'(PERIOD_CYC - 1);

  always_comb begin
    r_d = r_q;
    r_d.cnt = r_q.cnt + 32'h1;
    case (r_q.st)
      RS_IDLE: begin
        r_d.cnt = 32'h0;
        if (want_ring) begin
          r_d.st = RS_ENTRY;
        end
      end
      RS_ENTRY: begin
        if (!want_ring) begin
          r_d.st = RS_IDLE;
        end else if (match || expired) begin
          r_d.st = RS_ON;
        end
      end
      RS_ON: begin
        r_d.cnt = 32'h0;
        if (!want_ring) begin
          r_d.st = RS_EXIT;
        end
      end
      RS_EXIT: begin
        if (want_ring) begin
          r_d.st = RS_ON;
        end else if (match || expired) begin
          r_d.st = RS_IDLE;
        end
      end
      default: begin
        r_d.st = RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r_q <= '{st: RS_IDLE, cnt: 32'h0};
    end else begin
      r_q <= r_d;
    end
  end

  assign gen_on  = r_q.st != RS_IDLE;
  assign busy    = r_q.st != RS_IDLE;
  assign applied = (r_q.st == RS_ON) || (r_q.st == RS_EXIT);

  entry_bound_a: assert property (@(posedge clk) disable iff (rst) (r_q.st == RS_ENTRY) |-> (r_q.cnt < 32'(PERIOD_CYC))) else $error("ring entry overran one period");
  entry_wait_a: assert property (@(posedge clk) disable iff (rst) (r_q.st == RS_ENTRY && want_ring && !match && !expired) |=> !applied) else $error("ringing applied before match");
  exit_hold_a: assert property (@(posedge clk) disable iff (rst) (r_q.st == RS_EXIT && !want_ring && !match && !expired) |=> applied) else $error("ringing removed before match");

endmodule
`default_nettype wire

// ===== sim/slsc_line_model.sv
// Purpose: Far-side line model: ringing waveform, target level and trip detector
// Assumes: Same clock as the controller; target line voltage held at zero
// Notes:   Sawtooth period of 40 cycles stays inside the shortened ring period
`timescale 1ns/1ps
`default_nettype none
module slsc_line_model
  import slsc_pkg::*;
#(
  parameter int VW = 16
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Bench control
  input  wire logic                 trip_req,
  // Line side
  output logic signed [VW-1:0]      ring_v,
  output logic signed [VW-1:0]      target_v,
  output logic                      trip
);
  logic [5:0] ph_q;
  // Passes through zero once per period, so a match is always reachable
  always_ff @(posedge clk) begin
    if (rst) begin
      ph_q <= 6'h00;
      trip <= 1'b0;
    end else begin
      ph_q <= (ph_q == 6'h27) ? 6'h00 : ph_q + 6'h01;
      trip <= trip_req;
    end
  end
  assign ring_v   = VW'(int'(ph_q) * 20 - 400);
  assign target_v = '0;
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Purpose: Self-checking bench for the line state controller
// Assumes: Shortened calibration and ring periods
// Notes:   Line controls are sampled several cycles after each state write
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import slsc_pkg::*;
  localparam int CALC = 20;
  localparam int RINGC = 50;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, trip_req = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rd, dout;
  logic [3:0] sel = 4'h0;
  logic ack, trip, irq;
  logic signed [15:0] rv, tv;
  logic reg_on, reg_floor, reg_track, reg_fixed, drv_hiz, feed_en, hook_sup_en;
  logic voice_tx_en, voice_ch_en, rev_pol, tip_open, lp_bias_en, line_mon_en;
  logic ring_gen_en, ring_apply, bias_gen_en, ring_ilim_en, balanced_en;
  int err_count = 0;
  int num_checks = 0;
  logic [2:0] st_tab [4] = '{LS_STANDBY, LS_OHT, LS_ACTIVE, LS_TALK};
  logic [2:0] ex_tab [4] = '{3'h6, 3'h7, 3'h6, 3'h7};

  always #2.5 clk = ~clk;

  slsc_line_model #(.VW(16)) model (.clk(clk), .rst(rst), .trip_req(trip_req),
    .ring_v(rv), .target_v(tv), .trip(trip));

  slsc_top #(.CAL_CYCLES(CALC), .RING_CYCLES(RINGC), .VW(16)) uut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dout), .wb_ack_o(ack),
    .ring_trip(trip), .ring_inst_v(rv), .line_target_v(tv),
    .reg_on(reg_on), .reg_floor(reg_floor), .reg_track(reg_track), .reg_fixed(reg_fixed),
    .drv_hiz(drv_hiz), .feed_en(feed_en), .hook_sup_en(hook_sup_en),
    .voice_tx_en(voice_tx_en), .voice_ch_en(voice_ch_en), .rev_pol(rev_pol),
    .tip_open(tip_open), .lp_bias_en(lp_bias_en), .line_mon_en(line_mon_en),
    .ring_gen_en(ring_gen_en), .ring_apply(ring_apply), .bias_gen_en(bias_gen_en),
    .ring_ilim_en(ring_ilim_en), .balanced_en(balanced_en), .irq(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Holds the request until ack is sampled high at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hF;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = dout;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask

  task automatic set_st(input logic [3:0] s);
    bus(1'b1, ADDR_LINE_CTRL, {28'h0, s});
    repeat (5) @(posedge clk);
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    tally_and_finish;
  end

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({reg_on, voice_ch_en, feed_en, irq}, 4'h0);
    bus(1'b0, ADDR_LINE_CTRL, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    $display("test reset done");

    // Line init, then calibration as the host must do
    bus(1'b1, ADDR_CAL_CMD, 32'h2);
    repeat (5) @(posedge clk);
    bus(1'b0, ADDR_LINE_STAT, 32'h0);
    chk(rd[3:0], {1'b0, LS_DISCONNECT});
    chk({drv_hiz, reg_on, reg_floor, feed_en, voice_ch_en}, 5'h1C);
    bus(1'b1, ADDR_INT_STAT, 32'h7);
    bus(1'b1, ADDR_INT_MASK, 32'h1);
    bus(1'b1, ADDR_CAL_CMD, 32'h1);
    for (int i = 0; i < CALC + 20 && irq !== 1'b1; i++) @(posedge clk);
    chk(irq, 1'b1);
    bus(1'b0, ADDR_INT_STAT, 32'h0);
    chk(rd[INT_CAL_BIT], 1'b1);
    bus(1'b1, ADDR_INT_STAT, 32'h1);
    @(posedge clk);
    chk(irq, 1'b0);
    $display("test calibration done");

    // Feed, supervision and voice per state; masked state event
    for (int i = 0; i < 4; i++) begin
      set_st({1'b0, st_tab[i]});
      chk({feed_en, hook_sup_en, voice_tx_en}, ex_tab[i]);
      chk({drv_hiz, rev_pol, irq}, 3'h0);
    end
    set_st({1'b0, LS_TIP_OPEN});
    chk({feed_en, hook_sup_en, voice_tx_en, tip_open}, 4'hD);
    bus(1'b0, ADDR_INT_STAT, 32'h0);
    chk(rd[INT_STATE_BIT], 1'b1);
    set_st({1'b1, LS_TALK});
    chk({rev_pol, voice_tx_en}, 2'h3);
    bus(1'b0, ADDR_LINE_STAT, 32'h0);
    chk(rd[3:0], {1'b1, LS_TALK});
    bus(1'b1, ADDR_LINE_CFG, 32'h8);
    set_st({1'b0, LS_DISCONNECT});
    chk({drv_hiz, voice_ch_en, feed_en}, 3'h6);
    bus(1'b1, ADDR_LINE_CFG, 32'h1);
    set_st({1'b0, LS_STANDBY});
    chk({feed_en, lp_bias_en, line_mon_en, voice_tx_en}, 4'h6);
    $display("test states done");

    // Balanced tracking ringing, then trip exit
    bus(1'b1, ADDR_LINE_CFG, 32'h4);
    set_st({1'b0, LS_ACTIVE});
    bus(1'b1, ADDR_LINE_CTRL, {29'h0, LS_RINGING});
    repeat (3) @(posedge clk);
    for (int i = 0; i < RINGC + 10 && ring_apply !== 1'b1; i++) @(posedge clk);
    chk({ring_gen_en, ring_apply}, 2'h3);
    repeat (3) @(posedge clk);
    chk({bias_gen_en, ring_ilim_en}, 2'h3);
    chk({reg_track, reg_fixed}, 2'h2);
    chk(balanced_en, 1'b1);
    trip_req <= 1'b1;
    @(posedge clk);
    trip_req <= 1'b0;
    for (int i = 0; i < RINGC + 10 && ring_apply !== 1'b0; i++) @(posedge clk);
    chk(ring_apply, 1'b0);
    repeat (4) @(posedge clk);
    bus(1'b0, ADDR_LINE_STAT, 32'h0);
    chk(rd[3:0], {1'b0, LS_ACTIVE});
    bus(1'b0, ADDR_INT_STAT, 32'h0);
    chk(rd[INT_TRIP_BIT], 1'b1);
    chk(feed_en, 1'b1);
    // Fixed supply, reversed polarity, left by a new state request
    bus(1'b1, ADDR_LINE_CFG, 32'h2);
    bus(1'b1, ADDR_LINE_CTRL, {28'h0, 1'b1, LS_RINGING});
    for (int i = 0; i < RINGC + 10 && ring_apply !== 1'b1; i++) @(posedge clk);
    repeat (3) @(posedge clk);
    chk({ring_apply, reg_track, reg_fixed, balanced_en, rev_pol}, 5'h15);
    bus(1'b1, ADDR_LINE_CTRL, {28'h0, 1'b1, LS_TALK});
    for (int i = 0; i < RINGC + 10 && ring_apply !== 1'b0; i++) @(posedge clk);
    chk(ring_apply, 1'b0);
    repeat (4) @(posedge clk);
    bus(1'b0, ADDR_LINE_STAT, 32'h0);
    chk(rd[3:0], {1'b1, LS_TALK});
    set_st(4'h0);
    chk({reg_on, feed_en, ring_gen_en, voice_ch_en}, 4'h0);
    $display("test ringing done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
